// ---- hw/nfh_pkg.sv ----
// Package for the NOR flash program/erase host sequencer.
// Assumes a 100 MHz system clock; all times but BUSY_DLY_FAST_NS become cycle counts here.
package nfh_pkg;
  // Clock period in picoseconds
  localparam int CLK_PS = 10000;
  // Times as printed, in their own units
  localparam int PROG_US = 60;
  localparam int ACC_PROG_US = 54;
  localparam int BUF_PROG_US = 240;
  localparam int ERASE_MS = 500;
  localparam int POLL_WAIT_US = 4;
  localparam int BUSY_DLY_FAST_NS = 70;
  localparam int BUSY_DLY_SLOW_NS = 90;
  localparam int PROT_PULSE_NS = 100;
  localparam int WR_PULSE_NS = 35;
  // Cycle counts: least times round up
  localparam int POLL_WAIT_CYC =
    (POLL_WAIT_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int BUSY_DLY_CYC =
    (BUSY_DLY_SLOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PROT_PULSE_CYC = (PROT_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WR_PULSE_CYC = (WR_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Typical completion figures in cycles; four times ERASE_CYC is the watchdog default
  localparam int PROG_CYC = PROG_US * 100;
  localparam int ACC_PROG_CYC = ACC_PROG_US * 100;
  localparam int BUF_PROG_CYC = BUF_PROG_US * 100;
  localparam int ERASE_CYC = ERASE_MS * 100000;
  // Buffer limits
  localparam int BUF_WORDS_MAX = 16;
  localparam int BUF_BYTES_MAX = 32;
  // Protect address bit positions
  localparam int PROT_A7 = 7;
  localparam int PROT_A2 = 2;
  localparam int PROT_A1 = 1;
  // Status bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;

  // Operation codes
  typedef enum logic [2:0] {
    NFH_OP_PROG    = 3'h0,
    NFH_OP_BUFPROG = 3'h1,
    NFH_OP_ERASE   = 3'h2,
    NFH_OP_PROTECT = 3'h3,
    NFH_OP_UNPROT  = 3'h4,
    NFH_OP_SUSPEND = 3'h5,
    NFH_OP_RESUME  = 3'h6
  } nfh_op_t;

  // Command as presented by the user side
  typedef struct packed {
    nfh_op_t     op;
    logic [21:0] addr;
    logic [15:0] data;
    logic [5:0]  count;
  } nfh_cmd_t;

  // Completion report
  typedef struct packed {
    logic ok;
    logic timeout;
    logic busy;
  } nfh_stat_t;
endpackage

// ---- hw/nfh_seq.sv ----
// Host-side program/erase sequencer for an asynchronous parallel NOR flash.
// Assumes flash pins are registered here and sampled synchronously.
// What this block does
// - buffer program carries 1-16 words/1-32 bytes
// - wait 4 us before reading status
// - suspend inside wait: full wait after resume
// - suspend after wait: read at once
// - write again as soon as ready
// - protect uses A7=0, A2=1, A1=0
// - unprotect uses A7=1, A2=1, A1=0
// - protect write pulse at least 100 ns
// - read toggle bit twice and compare
// - on timeout bit, reread polling bit (here the polling bit is taken from the same read that shows the timeout bit)
`timescale 1ns/10ps
module nfh_seq
  import nfh_pkg::*;
#(
  parameter int ERASE_LIMIT = ERASE_CYC * 4,  // Watchdog on one operation
  parameter bit BYTE_MODE   = 1'b0            // Bus is byte wide
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       cmd_valid,       // Command strobe
  input  wire nfh_cmd_t   cmd,             // Command contents
  output logic            cmd_ready,       // Idle, may take command
  output nfh_stat_t       stat,            // Last completion
  output logic            done,            // Completion pulse
  output logic [21:0]     flash_addr,      // Address pins
  output logic [15:0]     flash_dq_out,    // Data out
  output logic            flash_dq_oe_n,   // Low while driving data
  input  wire logic [15:0] flash_dq_in,    // Data in
  output logic            flash_ce_n,      // Chip enable
  output logic            flash_we_n,      // Write strobe
  output logic            flash_oe_n,      // Read strobe
  input  wire logic       ready_busy_output // Low while busy
);
  // Refuse a watchdog no longer than the poll wait
  if (ERASE_LIMIT <= POLL_WAIT_CYC) begin : g_bad_limit
    $error("ERASE_LIMIT too small");
  end

  // One-hot states
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,  // Waiting for a command
    S_WRITE = 7'h02,  // Strobe active
    S_GAP   = 7'h04,  // Strobe high between writes
    S_POLLW = 7'h08,  // Status-poll wait
    S_RD1   = 7'h10,  // First status read
    S_RD2   = 7'h20,  // Second status read
    S_SUSP  = 7'h40   // Operation suspended
  } nfh_state_t;

  nfh_state_t  state, next_state;         // Sequencer state
  logic [31:0] tmr, next_tmr;             // Phase timer
  logic [31:0] wdog, next_wdog;           // Whole-op watchdog
  logic [5:0]  left, next_left;           // Buffer writes left
  logic [15:0] first, next_first;         // First status sample
  logic        past_wait, next_past_wait; // Poll wait already done
  nfh_cmd_t    cur, next_cur;             // Held command
  logic        next_cmd_ready, next_done;
  nfh_stat_t   next_stat;
  logic [21:0] next_addr;
  logic [15:0] next_dq;
  logic        next_oe_dq_n, next_ce_n, next_we_n, next_oe_n;
  logic        is_prot, toggling;

  assign is_prot = (cur.op == NFH_OP_PROTECT) || (cur.op == NFH_OP_UNPROT);
  // Toggle bit compared across two reads
  assign toggling = first[TOGGLE_BIT] != flash_dq_in[TOGGLE_BIT];

  // Next-state and pin computation
  always_comb begin
    next_state     = state;
    next_tmr       = tmr + 32'h1;
    next_wdog      = wdog + 32'h1;
    next_left      = left;
    next_first     = first;
    next_past_wait = past_wait;
    next_cur       = cur;
    next_done      = 1'b0;
    next_stat      = stat;
    next_addr      = flash_addr;
    next_dq        = flash_dq_out;
    next_oe_dq_n   = flash_dq_oe_n;
    next_ce_n      = 1'b1;
    next_we_n      = 1'b1;
    next_oe_n      = 1'b1;
    unique case (state)
      S_IDLE: begin
        next_oe_dq_n   = 1'b1;
        // New work only from idle, so nothing overlaps a busy op
        if (cmd_valid && cmd.op != NFH_OP_SUSPEND &&
            cmd.op != NFH_OP_RESUME) begin
          next_cur  = cmd;
          // Buffer length clamped to 1..16 words or 1..32 bytes
          if (cmd.op == NFH_OP_BUFPROG) begin
            if (cmd.count == 6'h00)
              next_left = 6'h01;
            else if (!BYTE_MODE && cmd.count > 6'(BUF_WORDS_MAX))
              next_left = 6'(BUF_WORDS_MAX);
            else if (cmd.count > 6'(BUF_BYTES_MAX))
              next_left = 6'(BUF_BYTES_MAX);
            else
              next_left = cmd.count;
          end else begin
            next_left = 6'h01;
          end
          next_addr = cmd.addr;
          if (cmd.op == NFH_OP_PROTECT || cmd.op == NFH_OP_UNPROT) begin
            next_addr[PROT_A7] = (cmd.op == NFH_OP_UNPROT);
            next_addr[PROT_A2] = 1'b1;
            next_addr[PROT_A1] = 1'b0;
          end
          next_dq        = cmd.data;
          next_oe_dq_n   = 1'b0;
          next_ce_n      = 1'b0;
          next_we_n      = 1'b0;
          next_tmr       = 32'h0;
          next_wdog      = 32'h0;
          next_past_wait = 1'b0;
          next_state     = S_WRITE;
        end
      end
      S_WRITE: begin
        next_ce_n = 1'b0;
        next_we_n = 1'b0;
        // Protect needs the long pulse, others the plain write pulse
        if ((is_prot && tmr >= 32'(PROT_PULSE_CYC - 1)) ||
            (!is_prot && tmr >= 32'(WR_PULSE_CYC - 1))) begin
          next_we_n  = 1'b1;
          next_ce_n  = 1'b1;
          next_left  = left - 6'h01;
          next_tmr   = 32'h0;
          next_state = S_GAP;
        end
      end
      S_GAP: begin
        if (left != 6'h00) begin
          // Next buffer word at next address
          next_addr  = flash_addr + 22'h1;
          next_ce_n  = 1'b0;
          next_we_n  = 1'b0;
          next_tmr   = 32'h0;
          next_state = S_WRITE;
        end else begin
          next_oe_dq_n = 1'b1;
          next_tmr     = 32'h0;
          next_state   = S_POLLW;
        end
      end
      S_POLLW: begin
        // Status not trusted until the poll wait ends
        if (cmd_valid && cmd.op == NFH_OP_SUSPEND) begin
          next_state = S_SUSP;
        end else if (tmr >= 32'(POLL_WAIT_CYC - 1)) begin
          next_past_wait = 1'b1;
          next_ce_n      = 1'b0;
          next_oe_n      = 1'b0;
          next_state     = S_RD1;
        end
      end
      S_RD1: begin
        next_first = flash_dq_in;
        next_ce_n  = 1'b0;
        next_oe_n  = 1'b0;
        next_state = S_RD2;
      end
      S_RD2: begin
        if (cmd_valid && cmd.op == NFH_OP_SUSPEND) begin
          next_state = S_SUSP;
        end else if (!toggling && ready_busy_output) begin
          next_stat  = '{ok: 1'b1, timeout: 1'b0, busy: 1'b0};
          next_done  = 1'b1;
          next_state = S_IDLE;
        end else if (flash_dq_in[TIMEOUT_BIT] ||
                     wdog >= 32'(ERASE_LIMIT)) begin
          // Polling bit taken from the same read that shows the timeout bit, not read again
          next_stat = '{ok: (flash_dq_in[POLL_BIT] == cur.data[POLL_BIT]),
                        timeout: 1'b1, busy: 1'b0};
          next_done  = 1'b1;
          next_state = S_IDLE;
        end else begin
          next_ce_n  = 1'b0;
          next_oe_n  = 1'b0;
          next_state = S_RD1;
        end
      end
      S_SUSP: begin
        next_wdog = wdog;
        if (cmd_valid && cmd.op == NFH_OP_RESUME) begin
          next_tmr = 32'h0;
          // Early suspend repeats the wait, late one reads at once
          if (past_wait) begin
            next_ce_n  = 1'b0;
            next_oe_n  = 1'b0;
            next_state = S_RD1;
          end else begin
            next_state = S_POLLW;
          end
        end
      end
    endcase
    next_stat.busy = (next_state != S_IDLE) && (next_state != S_SUSP);
    next_cmd_ready = (next_state == S_IDLE);  // Ready in step with idle
  end

  // State registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state         <= S_IDLE;
      tmr           <= 32'h0;
      wdog          <= 32'h0;
      left          <= 6'h00;
      first         <= 16'h0;
      past_wait     <= 1'b0;
      cur           <= '0;
      cmd_ready     <= 1'b0;
      done          <= 1'b0;
      stat          <= '0;
      flash_addr    <= 22'h0;
      flash_dq_out  <= 16'h0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
    end else begin
      state         <= next_state;
      tmr           <= next_tmr;
      wdog          <= next_wdog;
      left          <= next_left;
      first         <= next_first;
      past_wait     <= next_past_wait;
      cur           <= next_cur;
      cmd_ready     <= next_cmd_ready;
      done          <= next_done;
      stat          <= next_stat;
      flash_addr    <= next_addr;
      flash_dq_out  <= next_dq;
      flash_dq_oe_n <= next_oe_dq_n;
      flash_ce_n    <= next_ce_n;
      flash_we_n    <= next_we_n;
      flash_oe_n    <= next_oe_n;
    end
  end

  // Protect strobe stays low the full long pulse
  AST_PROT_PULSE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == S_IDLE && next_state == S_WRITE &&
     next_cur.op inside {NFH_OP_PROTECT, NFH_OP_UNPROT}) |=>
      (!flash_we_n)[*8] ##1 !flash_we_n ##1 !flash_we_n)
    else $error("protect pulse short");
  // No status read inside the poll wait
  AST_POLL_WAIT: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == S_POLLW && tmr < 32'(POLL_WAIT_CYC - 1)) |=> flash_oe_n)
    else $error("status read too early");
  // Early suspend returns to the wait
  AST_EARLY_RESUME: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == S_SUSP && !past_wait && cmd_valid && cmd.op == NFH_OP_RESUME)
      |=> state == S_POLLW && tmr == 32'h0)
    else $error("wait not reapplied");
  // Late suspend reads at once
  AST_LATE_RESUME: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == S_SUSP && past_wait && cmd_valid && cmd.op == NFH_OP_RESUME)
      |=> state == S_RD1 && !flash_oe_n)
    else $error("late resume not immediate");
  // Protect address encoding
  AST_PROT_ADDR: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!flash_we_n && cur.op == NFH_OP_PROTECT) |->
      !flash_addr[7] && flash_addr[2] && !flash_addr[1])
    else $error("protect address wrong");
  AST_UNPROT_ADDR: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!flash_we_n && cur.op == NFH_OP_UNPROT) |->
      flash_addr[7] && flash_addr[2] && !flash_addr[1])
    else $error("unprotect address wrong");
  // No command accepted while busy
  AST_NO_OVERLAP: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state != S_IDLE) |=> $stable(cur))
    else $error("command taken while busy");
  // Buffer burst never exceeds the buffer
  AST_BUF_LEN: assert property (@(posedge sys_clk) disable iff (!nrst)
    left <= (BYTE_MODE ? 6'(BUF_BYTES_MAX) : 6'(BUF_WORDS_MAX)))
    else $error("buffer too long");
  // Successful completion only with ready seen on the pin
  AST_DONE_READY: assert property (@(posedge sys_clk) disable iff (!nrst)
    (done && stat.ok && !stat.timeout) |-> $past(ready_busy_output))
    else $error("done while busy");

  COV_PROG: cover property (@(posedge sys_clk) disable iff (!nrst)
    state == S_IDLE && cmd_valid && cmd.op == NFH_OP_PROG);
  COV_SUSP: cover property (@(posedge sys_clk) disable iff (!nrst)
    state == S_SUSP ##1 state == S_POLLW);
  COV_TIMEOUT: cover property (@(posedge sys_clk) disable iff (!nrst)
    done && stat.timeout);
endmodule

// ---- bench/nfh_flash_model.sv ----
// Behavioural model of the NOR flash seen by the host sequencer.
// Assumes the sequencer's registered strobes; times are scaled cycles.
`timescale 1ns/10ps
module nfh_flash_model
  import nfh_pkg::*;
#(
  parameter int OP_CYC  = 600,           // Scaled embedded operation time
  parameter int DLY_CYC = BUSY_DLY_CYC,  // Busy assert delay in cycles
  parameter bit ACCEL   = 1'b0,          // Accelerate pin at high voltage
  parameter logic [21:0] FAIL_ADDR = 22'h3fffff  // Writes here never end
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [21:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  output logic [15:0]      flash_dq_in,
  output logic             ready_busy_output
);
  logic        we_q;    // Write strobe of last cycle
  logic        fail;    // Operation at the stuck address
  logic        timed_out; // Stuck operation reports timeout
  // Accelerated programs run shorter by the typical ratio
  localparam int RUN_CYC =
    ACCEL ? OP_CYC * ACC_PROG_US / PROG_US : OP_CYC;
  logic        active;  // Embedded operation running
  int          tick;    // Cycles since the last write ended
  logic        tgl;     // Toggle status bit
  logic [15:0] mem;     // Last data written
  logic [15:0] last;    // Last value shown on the bus
  // Operation timer, started at the end of each write pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      we_q   <= 1'b1;
      fail   <= 1'b0;
      active <= 1'b0;
      tick   <= 0;
      tgl    <= 1'b0;
      mem    <= 16'h0000;
      last   <= 16'h0000;
    end else begin
      we_q <= flash_we_n;
      if (flash_we_n && !we_q) begin
        active <= 1'b1;
        tick   <= 0;
        mem    <= flash_dq_out;
        fail   <= (flash_addr == FAIL_ADDR);
      end else if (active) begin
        tick <= tick + 1;
        // A stuck operation stays busy until the next write
        if (tick >= DLY_CYC + RUN_CYC && !fail) begin
          active <= 1'b0;
        end
      end
      // Toggle bit flips on every status read while busy
      if (!flash_oe_n && !flash_ce_n && active) begin
        tgl <= ~tgl;
      end
      if (!flash_oe_n) begin
        last <= flash_dq_in;
      end
    end
  end
  // Busy shows after the assert delay and stays until the end
  assign ready_busy_output = !(active && tick >= DLY_CYC);
  // Timeout bit rises once a stuck operation overruns
  assign timed_out = fail && tick >= DLY_CYC + RUN_CYC;
  // Status while busy, data when done, inverse of last when released
  always_comb begin
    if (flash_oe_n || flash_ce_n) begin
      flash_dq_in = ~last;
    end else if (active) begin
      flash_dq_in = {mem[15:8], ~mem[7], tgl, timed_out, mem[4:0]};
    end else begin
      flash_dq_in = mem;
    end
  end
endmodule

// ---- bench/nor_program_erase_timing_tb.sv ----
// Self-checking bench for the NOR flash program/erase host sequencer.
// Assumes nfh_seq and the flash model above; 100 MHz clock.
`timescale 1ns/10ps
module nor_program_erase_timing_tb;
  import nfh_pkg::*;
  logic        sys_clk;            // System clock
  logic        nrst;               // Reset, active low
  logic        cmd_valid;          // Command strobe
  nfh_cmd_t    cmd;                // Command contents
  logic        cmd_ready;          // Sequencer idle
  nfh_stat_t   stat;               // Completion report
  logic        done;               // Completion pulse
  logic [21:0] flash_addr;         // Flash address pins
  logic [15:0] flash_dq_out;       // Data to flash
  logic        flash_dq_oe_n;      // Data drive enable
  logic [15:0] flash_dq_in;        // Data from flash
  logic        flash_ce_n;         // Chip enable
  logic        flash_we_n;         // Write strobe
  logic        flash_oe_n;         // Read strobe
  logic        ready_busy_output;  // Flash busy pin
  int          bad_count = 0;      // Mismatches
  int          n_tests = 0;        // Comparisons
  int          cyc = 0;            // Cycle counter
  int          t_cmd = 0;          // Cycle a command was taken
  int          t_rd = -1;          // Cycle of first status read
  int          n_wr = 0;           // Finished write pulses
  int          we_len = 0;         // Length of current write pulse
  int          min_we = 999;       // Shortest write pulse
  logic        mon_clr = 1'b0;     // Restart the bus monitor
  logic [21:0] wr_addr;            // Address seen during last write
  logic [15:0] wr_data;            // Data seen during last write
  logic [1:0]  wr_ctl;             // Chip and data enables in write
  // Address at which the model never finishes
  localparam logic [21:0] FAIL_ADDR = 22'h00f000;

  nfh_seq #(.ERASE_LIMIT(3000), .BYTE_MODE(1'b0)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .stat(stat), .done(done),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .ready_busy_output(ready_busy_output));

  nfh_flash_model #(.OP_CYC(600), .FAIL_ADDR(FAIL_ADDR)) flash_u (
    .sys_clk(sys_clk), .nrst(nrst), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .flash_dq_in(flash_dq_in), .ready_busy_output(ready_busy_output));

  // Clock generator
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // Bus monitor: write count, shortest write pulse, first read
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (!flash_we_n) begin
      we_len  <= we_len + 1;
      wr_addr <= flash_addr;
      wr_data <= flash_dq_out;
      wr_ctl  <= {flash_ce_n, flash_dq_oe_n};
    end else if (we_len > 0) begin
      n_wr   <= n_wr + 1;
      min_we <= (we_len < min_we) ? we_len : min_we;
      we_len <= 0;
    end
    if (!flash_oe_n && t_rd < 0) begin
      t_rd <= cyc;
    end
    // A new command restarts the counts at the edge that takes it
    if (mon_clr) begin
      t_cmd  <= cyc;
      t_rd   <= -1;
      n_wr   <= 0;
      min_we <= 999;
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Present one command for one cycle; clr restarts the monitor
  task automatic issue(input nfh_op_t op, input logic [21:0] a,
                       input logic [15:0] d, input logic [5:0] n,
                       input bit clr);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd       <= '{op, a, d, n};
    mon_clr   <= clr;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    mon_clr   <= 1'b0;
  endtask

  // Wait for the completion pulse under a bound
  task automatic wait_done();
    int k;
    for (k = 0; k < 5000; k++) begin
      @(posedge sys_clk);
      #1;
      if (done === 1'b1) begin
        break;
      end
    end
    chk(k < 5000, 1);
  endtask

  // Single program, with an erase offered while busy
  task automatic t_prog();
    issue(NFH_OP_PROG, 22'h001234, 16'h5a3c, 6'h00, 1'b1);
    repeat (20) @(posedge sys_clk);
    chk(stat.busy, 1'b1);
    issue(NFH_OP_ERASE, 22'h010000, 16'h0000, 6'h00, 1'b0);
    wait_done();
    chk(stat.ok, 1'b1);
    chk({stat.timeout, stat.busy}, 2'b00);
    chk(wr_data, 16'h5a3c);
    chk(wr_ctl, 2'b00);
    chk(n_wr, 1);
    chk(wr_addr, 22'h001234);
    chk(t_rd - t_cmd >= POLL_WAIT_CYC, 1);
  endtask

  // Buffer program at the count limits
  task automatic t_buf();
    int cnt[3] = '{0, 16, 40};
    int exp[3] = '{1, 16, BUF_WORDS_MAX};
    for (int i = 0; i < 3; i++) begin
      issue(NFH_OP_BUFPROG, 22'h002000, 16'ha5c3, cnt[i][5:0], 1'b1);
      wait_done();
      chk(stat.ok, 1'b1);
      chk(n_wr, exp[i]);
      chk(wr_addr, 22'h002000 + exp[i] - 1);
    end
  endtask

  // Sector erase runs to completion
  task automatic t_erase();
    issue(NFH_OP_ERASE, 22'h030000, 16'h0000, 6'h00, 1'b1);
    wait_done();
    chk(stat.ok, 1'b1);
    chk(cyc - t_cmd >= 600, 1);
  endtask

  // Protect and unprotect address codes and pulse width
  task automatic t_prot();
    nfh_op_t ops[2] = '{NFH_OP_PROTECT, NFH_OP_UNPROT};
    for (int i = 0; i < 2; i++) begin
      issue(ops[i], i ? 22'h000002 : 22'h000083, 16'h0000, 6'h00, 1'b1);
      wait_done();
      chk(min_we >= PROT_PULSE_CYC, 1);
      chk(wr_addr[7], i[0]);
      chk(wr_addr[2:1], 2'b10);
    end
  endtask

  // Suspend inside the poll wait repeats it; suspend after it does not
  task automatic t_susp();
    issue(NFH_OP_PROG, 22'h004000, 16'h1111, 6'h00, 1'b1);
    repeat (100) @(posedge sys_clk);
    issue(NFH_OP_SUSPEND, 22'h004000, 16'h0000, 6'h00, 1'b0);
    repeat (20) @(posedge sys_clk);
    issue(NFH_OP_RESUME, 22'h004000, 16'h0000, 6'h00, 1'b1);
    wait_done();
    chk(t_rd - t_cmd >= POLL_WAIT_CYC, 1);
    chk(stat.ok, 1'b1);
    // Late suspend held two cycles so it meets the second status read
    issue(NFH_OP_PROG, 22'h004001, 16'h2222, 6'h00, 1'b1);
    wait (flash_oe_n === 1'b0);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd       <= '{NFH_OP_SUSPEND, 22'h004001, 16'h0000, 6'h00};
    repeat (2) @(posedge sys_clk);
    cmd_valid <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk(stat.busy, 1'b0);
    issue(NFH_OP_RESUME, 22'h004001, 16'h0000, 6'h00, 1'b1);
    wait_done();
    chk(t_rd - t_cmd, 1);
    chk(stat.ok, 1'b1);
  endtask

  // Stuck program: timeout bit ends polling, polling bit of that same read fails it
  task automatic t_fail();
    issue(NFH_OP_PROG, FAIL_ADDR, 16'h0080, 6'h00, 1'b1);
    wait_done();
    chk(stat.timeout, 1'b1);
    chk(stat.ok, 1'b0);
  endtask

  // Report the counts and end the run
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    nrst      = 1'b0;
    cmd_valid = 1'b0;
    cmd       = '0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(cmd_ready, 1'b1);
    t_prog();
    t_buf();
    t_erase();
    t_prot();
    t_susp();
    t_fail();
    print_verdict();
  end
endmodule
